// ---- fcs_pkg.sv ----
// Shared constants for the four-channel bus switch control block
// Function
// [RULE_01] Master sends seven-bit address, then direction bit
// [RULE_02] Direction bit one reads, zero writes
// [RULE_03] Byte after acknowledged address enters control register
// [RULE_04] Later write bytes overwrite; last byte kept
// [RULE_05] Control register readable as channel status
// [RULE_06] Low four bits enable channels; rest ignored
// [RULE_07] New selection applies only after STOP
// [RULE_08] Register resets to zero, no channel connected
// [RULE_09] Any channel combination may be enabled
// [RULE_10] Reset input clears state machine, deselects channels
// [RULE_11] Three select pins set address bits
// [RULE_12] Static up to fast-mode clock rate
// [RULE_13] Enabled channel joins upstream pair to downstream
// [RULE_14] Acknowledge address and each written byte
// [RULE_15] After master NACK, release data line
// [RULE_16] Reset zeroes every register; line history and filtered clock and data bits load the idle level instead
// [RULE_17] Select pins compared with address low bits
// [RULE_18] Mismatch: no acknowledge, ignore until START
`default_nettype none
package fcs_pkg;
    // Channel count and register width
    localparam int NUM_CHAN = 4;
    localparam int CTRL_WIDTH = 8;
    localparam int ADDR_UPPER_WIDTH = 4;
    localparam int ADDR_SEL_WIDTH = 3;
    // Control register reset value
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Field positions inside the control register
    localparam int CHAN_EN_LSB = 0;
    localparam int CHAN_EN_MSB = 3;
    // Fixed upper address bits, arbitrary plain default
    localparam logic [3:0] ADDR_UPPER_DEFAULT = 4'h7;
    // Bit position of the direction flag in the address byte
    localparam int DIR_BIT = 0;
    localparam logic DIR_READ = 1'b1;
    // Idle level of the bus lines after the input filter
    localparam logic LINE_IDLE = 1'b1;
    // Fastest serial clock accepted, and the system clock rate
    localparam int SCL_MAX_HZ = 400000;
    localparam int SYS_CLK_HZ = 50000000;
    // Shortest serial clock period in system cycles, rounded up
    localparam int SCL_MIN_PERIOD_CYC = (SYS_CLK_HZ + SCL_MAX_HZ - 1) / SCL_MAX_HZ;
    // Bus interface states
    typedef enum logic [2:0] {
        FCS_IDLE,
        FCS_ADDR,
        FCS_ACK,
        FCS_WRITE,
        FCS_READ,
        FCS_RDACK
    } fcs_state_e;
endpackage : fcs_pkg
`default_nettype wire

// ---- fcs_switch_top.sv ----
// Four-channel bus switch: serial slave, control register, channel pass logic
`timescale 1ns/10ps
`default_nettype none
module fcs_switch_top #(
    parameter logic [3:0] ADDR_UPPER = fcs_pkg::ADDR_UPPER_DEFAULT,
    parameter int NCH = fcs_pkg::NUM_CHAN
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic linkClk,
    input wire logic addrSelectIn0,
    input wire logic addrSelectIn1,
    input wire logic addrSelectIn2,
    input wire logic upSclIn,
    output logic upSclOut,
    output logic upSclOe,
    input wire logic upSdaIn,
    output logic upSdaOut,
    output logic upSdaOe,
    input wire logic [NCH-1:0] downClockIn,
    output logic [NCH-1:0] downClockOut,
    output logic [NCH-1:0] downClockOe,
    input wire logic [NCH-1:0] downDataIn,
    output logic [NCH-1:0] downDataOut,
    output logic [NCH-1:0] downDataOe,
    output logic [NCH-1:0] chanEnable
);
    ////////////////////////////////////////////////////////////////////////////////
    // Link domain: filtered pins
    logic sclS; // Filtered serial clock
    logic sdaS; // Filtered serial data
    logic [2:0] addrSel; // Filtered address select pins

    // Pins cross into the link clock through the agreement filter
    fcs_sync #(
        .WIDTH(5),
        .RESET_VAL({3'h0, fcs_pkg::LINE_IDLE, fcs_pkg::LINE_IDLE})
    ) u_pin_sync (
        .clk(linkClk),
        .rst_b(rst_b),
        .din({addrSelectIn2, addrSelectIn1, addrSelectIn0, upSdaIn, upSclIn}),
        .dout({addrSel, sdaS, sclS})
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Link domain registers
    fcs_pkg::fcs_state_e state_r, state_nxt; // Bus interface state
    logic sclP_r; // Serial clock one cycle ago
    logic sdaP_r; // Serial data one cycle ago
    logic [2:0] bitCnt_r, bitCnt_nxt; // Bit position in byte
    logic [7:0] shift_r, shift_nxt; // Receive and send shifter
    logic byteDone_r, byteDone_nxt; // Byte or acknowledge sampled
    logic [7:0] ctrl_r, ctrl_nxt; // Channel select control register
    logic sdaDrive_r, sdaDrive_nxt; // Device pulls data low
    logic rw_r, rw_nxt; // Direction of current transfer
    logic pending_r, pending_nxt; // Written value awaits STOP
    logic [3:0] applyWord_r; // Selection handed to system side
    logic applyTgl_r; // Flips once per handed selection

    // Bus conditions seen on the filtered lines
    wire logic sclRise = sclS & ~sclP_r; // [RULE_12]
    wire logic sclFall = ~sclS & sclP_r;
    wire logic startDet = sclS & sclP_r & sdaP_r & ~sdaS;
    wire logic stopDet = sclS & sclP_r & ~sdaP_r & sdaS;
    // Address compare: fixed upper bits plus select pins
    wire logic [6:0] ownAddr = {ADDR_UPPER, addrSel};
    wire logic addrHit = (shift_r[7:1] == ownAddr); // [RULE_11] [RULE_17]
    wire logic applyNow = stopDet & pending_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic of the bus interface
    always_comb
    begin
        state_nxt = state_r;
        bitCnt_nxt = bitCnt_r;
        shift_nxt = shift_r;
        byteDone_nxt = byteDone_r;
        ctrl_nxt = ctrl_r;
        sdaDrive_nxt = sdaDrive_r;
        rw_nxt = rw_r;
        pending_nxt = pending_r;
        if (startDet)
        begin
            // START or repeated START restarts addressing
            state_nxt = fcs_pkg::FCS_ADDR; // [RULE_01] [RULE_18]
            bitCnt_nxt = 3'h0;
            byteDone_nxt = 1'b0;
            sdaDrive_nxt = 1'b0;
        end
        else if (stopDet)
        begin
            // STOP ends any transfer and frees the line
            state_nxt = fcs_pkg::FCS_IDLE;
            sdaDrive_nxt = 1'b0;
            pending_nxt = 1'b0;
        end
        else
        begin
            case (state_r)
                fcs_pkg::FCS_ADDR, fcs_pkg::FCS_WRITE:
                begin
                    if (sclRise && !byteDone_r)
                    begin
                        // Sample one bit, MSB first
                        shift_nxt = {shift_r[6:0], sdaS};
                        bitCnt_nxt = 3'(bitCnt_r + 3'h1);
                        byteDone_nxt = (bitCnt_r == 3'h7);
                    end
                    else if (sclFall && byteDone_r)
                    begin
                        byteDone_nxt = 1'b0;
                        if (state_r == fcs_pkg::FCS_ADDR)
                        begin
                            if (addrHit)
                            begin
                                // Acknowledge own address
                                state_nxt = fcs_pkg::FCS_ACK; // [RULE_14]
                                sdaDrive_nxt = 1'b1;
                                rw_nxt = (shift_r[fcs_pkg::DIR_BIT] == fcs_pkg::DIR_READ); // [RULE_02]
                            end
                            else
                            begin
                                // Not ours: stay silent until next START
                                state_nxt = fcs_pkg::FCS_IDLE; // [RULE_18]
                            end
                        end
                        else
                        begin
                            // Every data byte replaces the register
                            ctrl_nxt = shift_r; // [RULE_03] [RULE_04]
                            pending_nxt = 1'b1;
                            state_nxt = fcs_pkg::FCS_ACK; // [RULE_14]
                            sdaDrive_nxt = 1'b1;
                        end
                    end
                end
                fcs_pkg::FCS_ACK:
                begin
                    if (sclFall)
                    begin
                        bitCnt_nxt = 3'h0;
                        if (rw_r)
                        begin
                            // Put register MSB on the line
                            state_nxt = fcs_pkg::FCS_READ; // [RULE_05]
                            shift_nxt = ctrl_r;
                            sdaDrive_nxt = ~ctrl_r[7];
                        end
                        else
                        begin
                            state_nxt = fcs_pkg::FCS_WRITE;
                            sdaDrive_nxt = 1'b0;
                        end
                    end
                end
                fcs_pkg::FCS_READ:
                begin
                    if (sclFall)
                    begin
                        bitCnt_nxt = 3'(bitCnt_r + 3'h1);
                        if (bitCnt_r == 3'h7)
                        begin
                            // Release for the master acknowledge
                            state_nxt = fcs_pkg::FCS_RDACK;
                            sdaDrive_nxt = 1'b0;
                        end
                        else
                        begin
                            shift_nxt = {shift_r[6:0], 1'b0};
                            sdaDrive_nxt = ~shift_r[6];
                        end
                    end
                end
                fcs_pkg::FCS_RDACK:
                begin
                    if (sclRise)
                    begin
                        if (sdaS)
                        begin
                            // Master NACK: keep line released
                            state_nxt = fcs_pkg::FCS_IDLE; // [RULE_15]
                        end
                        else
                        begin
                            byteDone_nxt = 1'b1;
                        end
                    end
                    else if (sclFall && byteDone_r)
                    begin
                        // Master acknowledged: send register again
                        byteDone_nxt = 1'b0;
                        state_nxt = fcs_pkg::FCS_READ; // [RULE_05]
                        shift_nxt = ctrl_r;
                        bitCnt_nxt = 3'h0;
                        sdaDrive_nxt = ~ctrl_r[7];
                    end
                end
                default:
                begin
                    state_nxt = state_r;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Link domain state registers, all reset; cleared except the line history, which loads the idle level
    always_ff @(posedge linkClk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= fcs_pkg::FCS_IDLE; // [RULE_10]
            sclP_r <= fcs_pkg::LINE_IDLE;
            sdaP_r <= fcs_pkg::LINE_IDLE;
            bitCnt_r <= 3'h0;
            shift_r <= 8'h00;
            byteDone_r <= 1'b0;
            ctrl_r <= fcs_pkg::CTRL_RESET; // [RULE_08] [RULE_16]
            sdaDrive_r <= 1'b0;
            rw_r <= 1'b0;
            pending_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            sclP_r <= sclS;
            sdaP_r <= sdaS;
            bitCnt_r <= bitCnt_nxt;
            shift_r <= shift_nxt;
            byteDone_r <= byteDone_nxt;
            ctrl_r <= ctrl_nxt;
            sdaDrive_r <= sdaDrive_nxt;
            rw_r <= rw_nxt;
            pending_r <= pending_nxt;
        end
    end

    // Selection handed over only on STOP; word settles before toggle is seen
    always_ff @(posedge linkClk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            applyWord_r <= 4'h0;
            applyTgl_r <= 1'b0;
        end
        else if (applyNow)
        begin
            applyWord_r <= ctrl_r[fcs_pkg::CHAN_EN_MSB:fcs_pkg::CHAN_EN_LSB]; // [RULE_06] [RULE_07]
            applyTgl_r <= ~applyTgl_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // System domain: take the handed selection
    logic applySync; // Toggle after the filter
    logic applySeen_r; // Last toggle level taken
    logic [NCH-1:0] chanEn_r; // Active channel switches

    fcs_sync #(
        .WIDTH(1),
        .RESET_VAL(1'b0)
    ) u_apply_sync (
        .clk(sys_clk),
        .rst_b(rst_b),
        .din(applyTgl_r),
        .dout(applySync)
    );

    wire logic applyPulse = applySync ^ applySeen_r;

    // Switch states change only when a new selection arrives
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            applySeen_r <= 1'b0;
            chanEn_r <= '0; // [RULE_10]
        end
        else
        begin
            applySeen_r <= applySync;
            if (applyPulse)
            begin
                chanEn_r <= NCH'(applyWord_r); // [RULE_07] [RULE_09]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pass gates: each enabled channel joins its pair to the upstream pair
    logic [NCH-1:0] clkUp; // Downstream holding clock low
    logic [NCH-1:0] dataUp; // Downstream holding data low

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++)
        begin : g_chan
            // Pull downstream low while upstream is low, unless this channel holds it
            assign downClockOe[ch] = chanEn_r[ch] & ~upSclIn & ~clkUp[ch]; // [RULE_13]
            assign downDataOe[ch] = chanEn_r[ch] & ~upSdaIn & ~dataUp[ch]; // [RULE_13]
            // Pull upstream low while a downstream device does
            assign clkUp[ch] = chanEn_r[ch] & ~downClockIn[ch] & ~downClockOe[ch];
            assign dataUp[ch] = chanEn_r[ch] & ~downDataIn[ch] & ~downDataOe[ch];
        end
    endgenerate

    // Open-drain outputs only ever drive low
    assign downClockOut = '0;
    assign downDataOut = '0;
    assign upSclOut = 1'b0;
    assign upSdaOut = 1'b0;
    assign upSclOe = |clkUp;
    assign upSdaOe = sdaDrive_r | (|dataUp); // [RULE_14]
    assign chanEnable = chanEn_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_addr_end;
        sclFall && byteDone_r && (state_r == fcs_pkg::FCS_ADDR);
    endsequence

    sequence s_data_end;
        !startDet && !stopDet && sclFall && byteDone_r && (state_r == fcs_pkg::FCS_WRITE);
    endsequence

    a_addr_ack: assert property (@(posedge linkClk) disable iff (!rst_b) // [RULE_14]
        (!startDet && !stopDet) ##0 s_addr_end ##0 addrHit |=> sdaDrive_r && (state_r == fcs_pkg::FCS_ACK))
        else $error("Own address not acknowledged");

    a_addr_miss: assert property (@(posedge linkClk) disable iff (!rst_b) // [RULE_18]
        (!startDet && !stopDet) ##0 s_addr_end ##0 !addrHit |=> !sdaDrive_r && (state_r == fcs_pkg::FCS_IDLE))
        else $error("Foreign address acknowledged");

    a_write_store: assert property (@(posedge linkClk) disable iff (!rst_b) // [RULE_03]
        s_data_end |=> (ctrl_r == $past(shift_r)) && pending_r)
        else $error("Written byte not stored");

    a_ctrl_hold: assert property (@(posedge linkClk) disable iff (!rst_b) // [RULE_04]
        (state_r != fcs_pkg::FCS_WRITE) |=> $stable(ctrl_r))
        else $error("Register changed outside a write");

    a_apply_stop: assert property (@(posedge linkClk) disable iff (!rst_b) // [RULE_07]
        !applyNow |=> $stable(applyTgl_r) && $stable(applyWord_r))
        else $error("Selection handed over without STOP");

    a_read_bit: assert property (@(posedge linkClk) disable iff (!rst_b) // [RULE_05]
        (state_r == fcs_pkg::FCS_READ) |-> (sdaDrive_r == ~shift_r[7]))
        else $error("Read data bit wrong");

    a_nack_release: assert property (@(posedge linkClk) disable iff (!rst_b) // [RULE_15]
        (state_r == fcs_pkg::FCS_RDACK) |-> !sdaDrive_r)
        else $error("Data line held during master acknowledge");

    a_chan_apply: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE_07]
        !applyPulse |=> $stable(chanEn_r))
        else $error("Channels changed without a handed selection");

    a_chan_value: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE_06]
        applyPulse |=> (chanEn_r == NCH'($past(applyWord_r))))
        else $error("Channels differ from handed selection");

    a_chan_off: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE_13]
        (chanEn_r == '0) |-> (downClockOe == '0) && (downDataOe == '0) && !upSclOe)
        else $error("Disabled channel still passes the bus");
endmodule : fcs_switch_top
`default_nettype wire

// ---- fcs_sync.sv ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module fcs_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    ////////////////////////////////////////////////////////////////////////////////
    // Stage registers; first stage feeds only the second
    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage3_r;
    logic [WIDTH-1:0] out_r;
    // Bits where the last two stages disagree keep the old value
    wire logic [WIDTH-1:0] differ = stage2_r ^ stage3_r;
    wire logic [WIDTH-1:0] out_nxt = (stage3_r & ~differ) | (out_r & differ);

    ////////////////////////////////////////////////////////////////////////////////
    // Shift chain and filtered output
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stage1_r <= RESET_VAL;
            stage2_r <= RESET_VAL;
            stage3_r <= RESET_VAL;
            out_r <= RESET_VAL;
        end
        else
        begin
            stage1_r <= din;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
            out_r <= out_nxt;
        end
    end

    assign dout = out_r;
endmodule : fcs_sync
`default_nettype wire

// ---- fcs_up_master.sv ----
// Upstream bus master model that drives the switch's serial clock and data pair
`timescale 1ns/10ps
`default_nettype none
module fcs_up_master (
    input wire logic sys_clk,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sclPull,
    output logic sdaPull
);
    // Half bit period in system cycles; kept well above six link cycles
    int hp = 30;

    // Both lines released at time zero
    initial
    begin
        sclPull = 1'h0;
        sdaPull = 1'h0;
    end

    ////////////////////////////////////////////////////////////////
    // Wait a number of system cycles
    task automatic hold(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : hold

    // START from idle, or repeated START from a low clock
    task automatic busStart();
        sdaPull <= 1'h0;
        hold(hp);
        sclPull <= 1'h0;
        hold(hp);
        sdaPull <= 1'h1;
        hold(hp);
        sclPull <= 1'h1;
    endtask : busStart

    // STOP: data rises while the clock is high, then the bus is idle
    task automatic busStop();
        sdaPull <= 1'h1;
        hold(hp);
        sclPull <= 1'h0;
        hold(hp);
        sdaPull <= 1'h0;
        hold(hp);
    endtask : busStop

    // One bit: data set mid-low, sampled at the end of the high phase
    task automatic busBit(input logic b, output logic seen);
        hold(hp / 2);
        sdaPull <= ~b;
        hold(hp / 2);
        sclPull <= 1'h0;
        hold(1);
        // A device stretching the clock delays the high phase
        while (!sclIn)
        begin
            hold(1);
        end
        hold(hp - 1);
        seen = sdaIn;
        sclPull <= 1'h1;
    endtask : busBit

    // Eight bits most significant first, then the acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic ackTx, output logic [7:0] rx,
                        output logic ackRx);
        for (int i = 7; i >= 0; i--)
        begin
            busBit(tx[i], rx[i]);
        end
        busBit(ackTx, ackRx);
    endtask : xfer
endmodule : fcs_up_master
`default_nettype wire

// ---- test_i2c_four_channel_switch_control.sv ----
// Self-checking bench for the four-channel bus switch control block
`timescale 1ns/10ps
`default_nettype none
module test_i2c_four_channel_switch_control;
    // Clocks, reset and address straps
    logic sys_clk = 1'h0;
    logic linkClk = 1'h0;
    logic rst_b = 1'h0;
    logic [2:0] strap = 3'h0;
    // Master pulls and resolved wire levels
    wire logic sclPull;
    wire logic sdaPull;
    wire logic upScl;
    wire logic upSda;
    // Switch drive enables and downstream wire levels
    wire logic upSclOe;
    wire logic upSdaOe;
    wire logic [3:0] downClockOe;
    wire logic [3:0] downDataOe;
    wire logic [3:0] downClk;
    wire logic [3:0] downDat;
    wire logic [3:0] chanEnable;
    // Open-drain output levels of the switch
    wire logic upSclOut;
    wire logic upSdaOut;
    wire logic [3:0] downClockOut;
    wire logic [3:0] downDataOut;
    // Downstream devices holding a line low
    logic [3:0] dnClkPull = 4'h0;
    logic [3:0] dnDatPull = 4'h0;
    // Result counters
    int badCount = 0;
    int totalChecks = 0;
    int cycles = 0;

    // Open-drain wires with pull-ups
    assign upScl = ~(sclPull | (upSclOe & ~upSclOut));
    assign upSda = ~(sdaPull | (upSdaOe & ~upSdaOut));
    assign downClk = ~((downClockOe & ~downClockOut) | dnClkPull);
    assign downDat = ~((downDataOe & ~downDataOut) | dnDatPull);

    ////////////////////////////////////////////////////////////////
    // System clock 20 ns, link clock 30 ns at an unrelated phase
    initial
    begin
        forever #10 sys_clk = ~sys_clk;
    end
    initial
    begin
        #7;
        forever #15 linkClk = ~linkClk;
    end

    // Device under test
    fcs_switch_top dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .linkClk(linkClk),
        .addrSelectIn0(strap[0]), .addrSelectIn1(strap[1]), .addrSelectIn2(strap[2]),
        .upSclIn(upScl), .upSclOut(upSclOut), .upSclOe(upSclOe),
        .upSdaIn(upSda), .upSdaOut(upSdaOut), .upSdaOe(upSdaOe),
        .downClockIn(downClk), .downClockOut(downClockOut), .downClockOe(downClockOe),
        .downDataIn(downDat), .downDataOut(downDataOut), .downDataOe(downDataOe),
        .chanEnable(chanEnable)
    );

    // Upstream master
    fcs_up_master m (
        .sys_clk(sys_clk), .sclIn(upScl), .sdaIn(upSda),
        .sclPull(sclPull), .sdaPull(sdaPull)
    );

    ////////////////////////////////////////////////////////////////
    // Expected bus address for a strap setting
    function automatic logic [6:0] devAddr(input logic [2:0] s);
        return {fcs_pkg::ADDR_UPPER_DEFAULT, s};
    endfunction : devAddr

    // Expected channel enables for a control byte
    function automatic logic [3:0] chanOf(input logic [7:0] b);
        return b[3:0];
    endfunction : chanOf

    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        totalChecks++;
        if (seen !== exp)
        begin
            badCount++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Final counts and verdict
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", totalChecks, badCount);
        if (badCount == 0 && totalChecks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize

    // START plus address byte; returns the acknowledge level seen
    task automatic addr(input logic [6:0] a, input logic rd, output logic ack);
        logic [7:0] rx;
        m.busStart();
        m.xfer({a, rd}, 1'h1, rx, ack);
    endtask : addr

    // Write one byte and end with STOP
    task automatic wr(input logic [7:0] b);
        logic [7:0] rx;
        logic ack;
        addr(devAddr(strap), 1'h0, ack);
        m.xfer(b, 1'h1, rx, ack);
        check({7'h0, ack}, 8'h00);
        m.busStop();
    endtask : wr

    // Read the register; the master withholds acknowledge, no STOP yet
    task automatic rdReg(input logic [7:0] exp);
        logic [7:0] rx;
        logic ack;
        addr(devAddr(strap), 1'h1, ack);
        check({7'h0, ack}, 8'h00);
        m.xfer(8'hff, 1'h1, rx, ack);
        check(rx, exp);
        m.hold(20);
        check({7'h0, upSdaOe}, 8'h00);
    endtask : rdReg

    // Cycle ceiling against hangs
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            badCount++;
            $display("BAD t=%0t seen=%h exp=%h", $time, cycles, 0);
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        logic [7:0] b;
        logic [7:0] rx;
        logic ack;
        logic [3:0] prev;
        void'($urandom(32'h3a1c));
        prev = 4'h0;
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'h1;
        m.hold(20);
        // Reset defaults
        check({4'h0, chanEnable}, 8'h00);
        rdReg(8'h00);
        m.busStop();
        $display("test reset defaults done");
        // Every strap, two bytes, repeated START read, then STOP
        for (int s = 0; s < 8; s++)
        begin
            strap <= s[2:0];
            m.hold(20);
            b = (s == 0) ? 8'hff : (s == 1) ? 8'h00 : (s == 7) ? 8'h69 : 8'($urandom);
            addr(devAddr(s[2:0]), 1'h0, ack);
            check({7'h0, ack}, 8'h00);
            m.xfer(8'($urandom), 1'h1, rx, ack);
            m.xfer(b, 1'h1, rx, ack);
            check({7'h0, ack}, 8'h00);
            rdReg(b);
            check({4'h0, chanEnable}, {4'h0, prev});
            m.busStop();
            prev = chanOf(b);
            check({4'h0, chanEnable}, {4'h0, prev});
        end
        $display("test strap write read done");
        // Pass-through, then a foreign address is ignored
        strap <= 3'h5;
        m.hold(20);
        m.busStart();
        m.hold(2);
        check({downClockOe, downDataOe}, {prev, prev});
        m.xfer({devAddr(3'h2), 1'h0}, 1'h1, rx, ack);
        check({7'h0, ack}, 8'h01);
        m.xfer(8'h5a, 1'h1, rx, ack);
        check({7'h0, ack}, 8'h01);
        m.busStop();
        check({downClockOe, downDataOe}, 8'h00);
        check({4'h0, chanEnable}, {4'h0, prev});
        rdReg(b);
        m.busStop();
        // Downstream holds reach upstream and the other enabled channel
        dnClkPull <= 4'h8;
        dnDatPull <= 4'h1;
        m.hold(2);
        check({upSclOe, upSdaOe, 2'h0, downClockOe}, {2'h3, 2'h0, prev & 4'h7});
        check({4'h0, downDataOe}, {4'h0, prev & 4'he});
        dnClkPull <= 4'h0;
        dnDatPull <= 4'h0;
        m.hold(2);
        check({upSclOe, upSdaOe, 2'h0, downClockOe}, 8'h00);
        $display("test foreign address done");
        // Slow serial clock
        m.hp = 150;
        wr(8'h3c);
        m.hp = 30;
        check({4'h0, chanEnable}, 8'h0c);
        $display("test slow clock done");
        // Reset in the middle of a write
        wr(8'h0a);
        check({4'h0, chanEnable}, 8'h0a);
        addr(devAddr(strap), 1'h0, ack);
        m.xfer(8'h03, 1'h1, rx, ack);
        rst_b <= 1'h0;
        m.hold(5);
        check({3'h0, upSdaOe, chanEnable}, 8'h00);
        m.sclPull <= 1'h0;
        m.sdaPull <= 1'h0;
        m.hold(5);
        rst_b <= 1'h1;
        m.hold(20);
        rdReg(8'h00);
        m.busStop();
        check({4'h0, chanEnable}, 8'h00);
        $display("test mid-frame reset done");
        summarize();
    end
endmodule : test_i2c_four_channel_switch_control
`default_nettype wire
